// *** pkg/cdrr_pkg.sv ***
// package for the cable diagnostic result register bank
package cdrr_pkg;

    // register indices (printed offsets, not multiples of four)
    localparam logic [7:0]  IDX_REFLECT_CTRL   = 8'h16;
    localparam logic [7:0]  IDX_SAMPLE_WINDOW  = 8'h17;
    localparam logic [7:0]  IDX_PEAK_RESULT    = 8'h18;
    localparam logic [7:0]  IDX_THRESH_RESULT  = 8'h19;
    localparam logic [7:0]  IDX_VAR_CONTROL    = 8'h1A;
    localparam logic [7:0]  IDX_VAR_DATA       = 8'h1B;
    localparam int          ADDR_W             = 12;

    // field positions
    localparam int          CTRL_LAUNCH_BIT    = 11;
    localparam int          CTRL_NEGPK_BIT     = 7;
    localparam int          VAR_RDY_BIT        = 15;
    localparam int          VAR_FREEZE_BIT     = 3;
    localparam int          VAR_ENABLE_BIT     = 0;
    localparam int          THR_MET_BIT        = 8;

    // reset values and the receiver sample midpoint
    localparam logic [7:0]  WIN_BEGIN_RST      = 8'h00;
    localparam logic [7:0]  WIN_END_RST        = 8'hFF;
    localparam logic [5:0]  THRESH_RST         = 6'h20;
    localparam logic [5:0]  SAMPLE_MID         = 6'h20;

    // timing: one variance unit is 2^17 steps of 8 ns, 2^18 cycles of the 4 ns clock
    localparam int          VAR_UNIT_LOG2      = 17;
    localparam real         CLK_PERIOD_NS      = 4.0;
    localparam real         SAMPLE_STEP_NS     = 8.0;
    localparam int          STEP_CYCLES        = int'(SAMPLE_STEP_NS / CLK_PERIOD_NS);

    // axi responses
    localparam logic [1:0]  RESP_OKAY          = 2'h0;
    localparam logic [1:0]  RESP_SLVERR        = 2'h2;

    typedef enum logic [1:0] {
        CDRR_IDLE = 2'b00,
        CDRR_RUN  = 2'b01,
        CDRR_DONE = 2'b11
    } cdrr_state_t;

    typedef struct packed {
        logic [7:0] win_begin;
        logic [7:0] win_end;
        logic [5:0] threshold;
        logic       neg_peak;
    } cdrr_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [5:0] value;
    } cdrr_sample_t;

endpackage : cdrr_pkg

// *** src/cdrr_regs.sv ***
// cable diagnostic result and variance control register bank
//
// Our own choice: the AXI4-Lite interface to the registers.
module cdrr_regs #(
    parameter int VAR_UNIT_CYCLES = (1 << cdrr_pkg::VAR_UNIT_LOG2) * cdrr_pkg::STEP_CYCLES
) (
    // clock, reset, enable
    input  wire logic                        CORE_CLK_I,
    input  wire logic                        RST_N_I,
    input  wire logic                        CLK_EN_I,
    // axi4-lite write
    input  wire logic [cdrr_pkg::ADDR_W-1:0] AWADDR_I,
    input  wire logic                        AWVALID_I,
    output logic                             AWREADY_O,
    input  wire logic [31:0]                 WDATA_I,
    input  wire logic [3:0]                  WSTRB_I,
    input  wire logic                        WVALID_I,
    output logic                             WREADY_O,
    output logic [1:0]                       BRESP_O,
    output logic                             BVALID_O,
    input  wire logic                        BREADY_I,
    // axi4-lite read
    input  wire logic [cdrr_pkg::ADDR_W-1:0] ARADDR_I,
    input  wire logic                        ARVALID_I,
    output logic                             ARREADY_O,
    output logic [31:0]                      RDATA_O,
    output logic [1:0]                       RRESP_O,
    output logic                             RVALID_O,
    input  wire logic                        RREADY_I,
    // reflectometry path
    input  wire cdrr_pkg::cdrr_sample_t      REFLECT_SAMPLE_I,
    output logic                             LAUNCH_PULSE_O,
    output logic                             NEG_PEAK_SEL_O,
    // 100 mb receiver path
    input  wire cdrr_pkg::cdrr_sample_t      RX100_SAMPLE_I
);
    import cdrr_pkg::*;

    // bus state
    logic                    aw_got_ff, nxt_aw_got;
    logic                    w_got_ff, nxt_w_got;
    logic [ADDR_W-1:0]       awaddr_ff, nxt_awaddr;
    logic [31:0]             wdata_ff, nxt_wdata;
    logic [3:0]              wstrb_ff, nxt_wstrb;
    logic                    bvalid_ff, nxt_bvalid;
    logic [1:0]              bresp_ff, nxt_bresp;
    logic                    rvalid_ff, nxt_rvalid;
    logic [31:0]             rdata_ff, nxt_rdata;
    logic [1:0]              rresp_ff, nxt_rresp;

    // control and results
    cdrr_cfg_t               cfg_ff, nxt_cfg;
    logic [2:0]              pulse_width_ff, nxt_pulse_width;
    logic                    launch_ff, nxt_launch;
    cdrr_state_t             state_ff, nxt_state;
    logic [7:0]              tcount_ff, nxt_tcount;
    logic                    step_ff, nxt_step;
    logic [5:0]              peak_val_ff, nxt_peak_val;
    logic [7:0]              peak_time_ff, nxt_peak_time;
    logic                    peak_seen_ff, nxt_peak_seen;
    logic                    thr_met_ff, nxt_thr_met;
    logic [7:0]              thr_time_ff, nxt_thr_time;

    // variance
    logic                    var_en_ff, nxt_var_en;
    logic [1:0]              var_timer_ff, nxt_var_timer;
    logic                    var_freeze_ff, nxt_var_freeze;
    logic                    var_rdy_ff, nxt_var_rdy;
    logic [31:0]             var_acc_ff, nxt_var_acc;
    logic [31:0]             var_data_ff, nxt_var_data;
    logic [21:0]             var_cnt_ff, nxt_var_cnt;
    logic                    var_half_ff, nxt_var_half;

    logic                    wr_fire, rd_fire;
    logic [ADDR_W-3:0]       wr_idx, rd_idx;
    logic [15:0]             wv;
    logic                    in_window;
    logic [5:0]              s_val;
    logic                    better, thr_hit;
    logic [5:0]              dev;
    logic [21:0]             var_limit;
    logic [15:0]             rd_word;
    logic                    rd_hit, var_restart, var_load;

    assign wr_fire   = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_idx    = awaddr_ff[ADDR_W-1:2];
    assign rd_fire   = ARVALID_I && !rvalid_ff;
    assign rd_idx    = ARADDR_I[ADDR_W-1:2];
    assign wv        = wdata_ff[15:0];
    assign s_val     = REFLECT_SAMPLE_I.value;
    assign var_limit = 22'((({20'h0, var_timer_ff} + 22'h1) * 22'h2 * 22'(VAR_UNIT_CYCLES)));
    assign var_restart = wr_fire && wstrb_ff[0] && wstrb_ff[1] && wv[2:1] != var_timer_ff
                         && wr_idx == 10'(IDX_VAR_CONTROL);
    assign var_load  = var_en_ff && !var_restart && !var_freeze_ff
                       && (var_cnt_ff >= var_limit - 22'h000001);

    assign AWREADY_O      = !aw_got_ff;
    assign WREADY_O       = !w_got_ff;
    assign BVALID_O       = bvalid_ff;
    assign BRESP_O        = bresp_ff;
    assign ARREADY_O      = !rvalid_ff;
    assign RVALID_O       = rvalid_ff;
    assign RDATA_O        = rdata_ff;
    assign RRESP_O        = rresp_ff;
    assign LAUNCH_PULSE_O = launch_ff && (state_ff == CDRR_IDLE);
    assign NEG_PEAK_SEL_O = cfg_ff.neg_peak;

    // read mux; reserved bits read zero
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 16'h0000;
        case (rd_idx)
            10'(IDX_REFLECT_CTRL): rd_word = {4'h0, launch_ff, pulse_width_ff, cfg_ff.neg_peak,
                                              1'b0, cfg_ff.threshold};
            10'(IDX_SAMPLE_WINDOW): rd_word = {cfg_ff.win_begin, cfg_ff.win_end};
            10'(IDX_PEAK_RESULT): rd_word = {2'b00, peak_val_ff, peak_time_ff};
            10'(IDX_THRESH_RESULT): rd_word = {7'h00, thr_met_ff, thr_time_ff};
            10'(IDX_VAR_CONTROL): rd_word = {var_rdy_ff, 11'h000, var_freeze_ff, var_timer_ff,
                                             var_en_ff};
            10'(IDX_VAR_DATA): rd_word = var_half_ff ? var_data_ff[31:16] : var_data_ff[15:0];
            default: rd_hit = 1'b0;
        endcase
    end

    // bus handshake
    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_w_got  = w_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb  = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp  = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (AWVALID_I && !aw_got_ff) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = AWADDR_I;
        end
        if (WVALID_I && !w_got_ff) begin
            nxt_w_got = 1'b1;
            nxt_wdata = WDATA_I;
            nxt_wstrb = WSTRB_I;
        end
        if (wr_fire) begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = (wr_idx >= 10'(IDX_REFLECT_CTRL) && wr_idx <= 10'(IDX_VAR_DATA))
                         ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid_ff && BREADY_I) begin
            nxt_bvalid = 1'b0;
        end
        if (rd_fire) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = {16'h0000, rd_word};
            nxt_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff && RREADY_I) begin
            nxt_rvalid = 1'b0;
        end
    end

    // registers, capture and variance next state
    always_comb begin
        nxt_cfg         = cfg_ff;
        nxt_pulse_width = pulse_width_ff;
        nxt_launch      = launch_ff;
        nxt_state       = state_ff;
        nxt_tcount      = tcount_ff;
        nxt_step        = step_ff;
        nxt_peak_val    = peak_val_ff;
        nxt_peak_time   = peak_time_ff;
        nxt_peak_seen   = peak_seen_ff;
        nxt_thr_met     = thr_met_ff;
        nxt_thr_time    = thr_time_ff;
        nxt_var_en      = var_en_ff;
        nxt_var_timer   = var_timer_ff;
        nxt_var_freeze  = var_freeze_ff;
        nxt_var_rdy     = var_rdy_ff;
        nxt_var_acc     = var_acc_ff;
        nxt_var_data    = var_data_ff;
        nxt_var_cnt     = var_cnt_ff;
        nxt_var_half    = var_half_ff;

        // window gating on the 8 ns time count
        in_window = (tcount_ff >= cfg_ff.win_begin) && (tcount_ff <= cfg_ff.win_end);
        better    = !peak_seen_ff || (cfg_ff.neg_peak ? (s_val < peak_val_ff)
                                                      : (s_val > peak_val_ff));
        thr_hit   = cfg_ff.neg_peak ? (s_val < cfg_ff.threshold) : (s_val > cfg_ff.threshold);
        dev       = (RX100_SAMPLE_I.value >= SAMPLE_MID) ? (RX100_SAMPLE_I.value - SAMPLE_MID)
                                                         : (SAMPLE_MID - RX100_SAMPLE_I.value);

        // register writes; reserved bits dropped
        if (wr_fire && wstrb_ff[0] && wstrb_ff[1]) begin
            case (wr_idx)
                10'(IDX_REFLECT_CTRL): begin
                    nxt_pulse_width = wv[10:8];
                    nxt_cfg.neg_peak  = wv[CTRL_NEGPK_BIT];
                    nxt_cfg.threshold = wv[5:0];
                    if (wv[CTRL_LAUNCH_BIT]) begin
                        nxt_launch = 1'b1;
                    end
                end
                10'(IDX_SAMPLE_WINDOW): begin
                    nxt_cfg.win_begin = wv[15:8];
                    nxt_cfg.win_end   = wv[7:0];
                end
                10'(IDX_VAR_CONTROL): begin
                    nxt_var_en     = wv[VAR_ENABLE_BIT];
                    nxt_var_freeze = wv[VAR_FREEZE_BIT];
                    nxt_var_timer  = wv[2:1];
                    if (wv[2:1] != var_timer_ff) begin
                        nxt_var_cnt = 22'h000000;
                        nxt_var_acc = 32'h00000000;
                    end
                end
                default: ;
            endcase
        end

        case (state_ff)
            CDRR_IDLE: begin
                if (launch_ff) begin
                    nxt_state     = CDRR_RUN;
                    nxt_tcount    = 8'h00;
                    nxt_step      = 1'b0;
                    nxt_peak_val  = 6'h00;
                    nxt_peak_time = 8'h00;
                    nxt_peak_seen = 1'b0;
                    nxt_thr_met   = 1'b0;
                    nxt_thr_time  = 8'h00;
                end
            end
            CDRR_RUN: begin
                if (!step_ff && in_window && REFLECT_SAMPLE_I.valid) begin
                    if (better) begin
                        nxt_peak_val  = s_val;
                        nxt_peak_time = tcount_ff;
                        nxt_peak_seen = 1'b1;
                    end
                    if (thr_hit && !thr_met_ff) begin
                        nxt_thr_met  = 1'b1;
                        nxt_thr_time = tcount_ff;
                    end
                end
                nxt_step = !step_ff;
                if (step_ff) begin
                    if (tcount_ff >= cfg_ff.win_end || tcount_ff == 8'hFF) begin
                        nxt_state = CDRR_DONE;
                    end else begin
                        nxt_tcount = tcount_ff + 8'h01;
                    end
                end
            end
            CDRR_DONE: begin
                nxt_launch = 1'b0;
                nxt_state  = CDRR_IDLE;
            end
            default: nxt_state = CDRR_IDLE;
        endcase

        if (var_en_ff && !var_restart) begin
            if (RX100_SAMPLE_I.valid) begin
                nxt_var_acc = var_acc_ff + 32'(dev) * 32'(dev);
            end
            nxt_var_cnt = var_cnt_ff + 22'h000001;
            if (var_cnt_ff >= var_limit - 22'h000001) begin
                nxt_var_cnt = 22'h000000;
                // freeze holds data; last sample included
                if (!var_freeze_ff) begin
                    nxt_var_data = nxt_var_acc;
                    nxt_var_half = 1'b0;
                    nxt_var_rdy  = 1'b1;
                end
                nxt_var_acc = 32'h00000000;
            end
        end

        // two data reads clear; new load wins
        if (rd_fire && rd_idx == 10'(IDX_VAR_DATA)) begin
            nxt_var_half = !var_half_ff && !var_load;
            if (var_half_ff) begin
                nxt_var_freeze = 1'b0;
                nxt_var_rdy    = var_load;
            end
        end else if (rd_fire) begin
            nxt_var_half = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            aw_got_ff      <= 1'b0;
            w_got_ff       <= 1'b0;
            awaddr_ff      <= '0;
            wdata_ff       <= 32'h00000000;
            wstrb_ff       <= 4'h0;
            bvalid_ff      <= 1'b0;
            bresp_ff       <= RESP_OKAY;
            rvalid_ff      <= 1'b0;
            rdata_ff       <= 32'h00000000;
            rresp_ff       <= RESP_OKAY;
            cfg_ff         <= '{win_begin: WIN_BEGIN_RST, win_end: WIN_END_RST,
                                threshold: THRESH_RST, neg_peak: 1'b0};
            pulse_width_ff <= 3'h0;
            launch_ff      <= 1'b0;
            state_ff       <= CDRR_IDLE;
            tcount_ff      <= 8'h00;
            step_ff        <= 1'b0;
            peak_val_ff    <= 6'h00;
            peak_time_ff   <= 8'h00;
            peak_seen_ff   <= 1'b0;
            thr_met_ff     <= 1'b0;
            thr_time_ff    <= 8'h00;
            var_en_ff      <= 1'b0;
            var_timer_ff   <= 2'h0;
            var_freeze_ff  <= 1'b0;
            var_rdy_ff     <= 1'b0;
            var_acc_ff     <= 32'h00000000;
            var_data_ff    <= 32'h00000000;
            var_cnt_ff     <= 22'h000000;
            var_half_ff    <= 1'b0;
        end else if (CLK_EN_I) begin
            aw_got_ff      <= nxt_aw_got;
            w_got_ff       <= nxt_w_got;
            awaddr_ff      <= nxt_awaddr;
            wdata_ff       <= nxt_wdata;
            wstrb_ff       <= nxt_wstrb;
            bvalid_ff      <= nxt_bvalid;
            bresp_ff       <= nxt_bresp;
            rvalid_ff      <= nxt_rvalid;
            rdata_ff       <= nxt_rdata;
            rresp_ff       <= nxt_rresp;
            cfg_ff         <= nxt_cfg;
            pulse_width_ff <= nxt_pulse_width;
            launch_ff      <= nxt_launch;
            state_ff       <= nxt_state;
            tcount_ff      <= nxt_tcount;
            step_ff        <= nxt_step;
            peak_val_ff    <= nxt_peak_val;
            peak_time_ff   <= nxt_peak_time;
            peak_seen_ff   <= nxt_peak_seen;
            thr_met_ff     <= nxt_thr_met;
            thr_time_ff    <= nxt_thr_time;
            var_en_ff      <= nxt_var_en;
            var_timer_ff   <= nxt_var_timer;
            var_freeze_ff  <= nxt_var_freeze;
            var_rdy_ff     <= nxt_var_rdy;
            var_acc_ff     <= nxt_var_acc;
            var_data_ff    <= nxt_var_data;
            var_cnt_ff     <= nxt_var_cnt;
            var_half_ff    <= nxt_var_half;
        end
    end

endmodule : cdrr_regs

// *** tb/cdrr_monitor.sv ***
// port checker for the cable diagnostic register bank
module cdrr_monitor (
    // clock, reset and clock enable
    input wire logic                        CORE_CLK_I,
    input wire logic                        RST_N_I,
    input wire logic                        CLK_EN_I,
    // register bus
    input wire logic                        AWREADY_O,
    input wire logic [cdrr_pkg::ADDR_W-1:0] ARADDR_I,
    input wire logic                        ARVALID_I,
    input wire logic                        ARREADY_O,
    input wire logic [31:0]                 RDATA_O,
    input wire logic [1:0]                  RRESP_O,
    input wire logic                        RVALID_O,
    // capture path
    input wire logic                        LAUNCH_PULSE_O,
    input wire logic                        NEG_PEAK_SEL_O
);
    timeunit 1ns;
    timeprecision 1ps;
    import cdrr_pkg::*;
    logic [9:0] ar_idx_ff;
    logic [9:0] nxt_ar_idx;
    always_comb begin
        nxt_ar_idx = (ARVALID_I && ARREADY_O) ? ARADDR_I[11:2] : ar_idx_ff;
    end
    always_ff @(posedge CORE_CLK_I) begin
        ar_idx_ff <= nxt_ar_idx;
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    chk_launch_single: assert property (LAUNCH_PULSE_O && CLK_EN_I
        |=> !LAUNCH_PULSE_O) else $error("launch pulse too long");
    chk_launch_cause: assert property ($rose(LAUNCH_PULSE_O)
        |-> !$past(AWREADY_O) || !$past(AWREADY_O, 2)) else $error("launch without write");
    chk_negpk_write: assert property ($changed(NEG_PEAK_SEL_O)
        |-> !$past(AWREADY_O)) else $error("min mode moved without write");
    chk_peak_resv: assert property (RVALID_O && ar_idx_ff == 10'h018
        |-> RDATA_O[15:14] == 2'h0) else $error("peak reserved bits set");
    chk_thr_resv: assert property (RVALID_O && ar_idx_ff == 10'h019
        |-> RDATA_O[15:9] == 7'h00) else $error("threshold reserved bits set");
    chk_varc_resv: assert property (RVALID_O && ar_idx_ff == 10'h01A
        |-> RDATA_O[14:4] == 11'h000) else $error("variance reserved bits set");
    chk_upper_zero: assert property (RVALID_O
        |-> RDATA_O[31:16] == 16'h0000) else $error("upper read half not zero");
    chk_unmapped_err: assert property (RVALID_O && (ar_idx_ff < 10'h016 || ar_idx_ff > 10'h01B)
        |-> RRESP_O == RESP_SLVERR && RDATA_O == 32'h0) else $error("unmapped read not refused");
endmodule : cdrr_monitor

// *** tb/tb_top.sv ***
// self-checking bench for the cable diagnostic register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cdrr_pkg::*;
    localparam int UNIT = 8;
    logic              clk = 1'b0, rst_n = 1'b0, lnch_n = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0]       wdata = '0, rdata, rdv, ex;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid, launch, negpk, mode;
    logic [1:0]        bresp, rresp, rrs, brs;
    cdrr_sample_t      refl = '0, rx = 7'h63;
    logic [5:0]        vals [256], thr;
    logic [8:0]        cyc = '0, nc;
    logic [7:0]        b, e;
    int                n_mismatch = 0, checks = 0, seed = 93;
    always #2 clk = ~clk;
    cdrr_regs #(.VAR_UNIT_CYCLES(UNIT)) uut (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1),
        .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
        .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
        .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
        .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
        .RREADY_I(rready), .REFLECT_SAMPLE_I(refl), .LAUNCH_PULSE_O(launch),
        .NEG_PEAK_SEL_O(negpk), .RX100_SAMPLE_I(rx));
    // replay sample table, one entry per 8 ns step since launch
    always @(negedge clk) lnch_n = launch;
    always @(posedge clk) begin
        nc = lnch_n ? 9'h001 : cyc + 9'h001;
        cyc <= nc;
        refl <= {1'b1, vals[nc[8:1]]};
    end
    function automatic logic [31:0] exp_capture(input logic [7:0] wb, we, input logic neg,
                                                input logic [5:0] th);
        logic [5:0] pk;
        logic [7:0] pt, ht;
        logic       hit;
        pk = vals[wb];
        pt = wb;
        hit = 1'b0;
        ht = 8'h00;
        for (int k = wb; k <= we; k++) begin
            if (neg ? vals[k] < pk : vals[k] > pk) begin
                pk = vals[k];
                pt = 8'(k);
            end
            if (!hit && (neg ? vals[k] < th : vals[k] > th)) begin
                hit = 1'b1;
                ht = 8'(k);
            end
        end
        return {7'h00, hit, ht, 2'h0, pk, pt};
    endfunction : exp_capture
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic pa, pw;
        @(posedge clk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            pa = pa && !awready;
            pw = pw && !wready;
            @(posedge clk);
            awvalid <= pa;
            wvalid <= pw;
        end
        do @(negedge clk); while (!bvalid);
        brs = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] idx);
        @(posedge clk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (!rvalid);
        rdv = rdata;
        rrs = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask : rd
    task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
        rd(idx);
        check(rdv, exp);
    endtask : rc
    task automatic close_out;
        $display("mismatches %0d of %0d checks", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    initial begin
        #400000;
        n_mismatch++;
        close_out();
    end
    initial begin
        foreach (vals[i]) vals[i] = 6'h20;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rc(IDX_SAMPLE_WINDOW, 32'h0000_00FF);
        rc(IDX_PEAK_RESULT, 32'h0);
        rc(IDX_THRESH_RESULT, 32'h0);
        rc(IDX_VAR_CONTROL, 32'h0);
        rd(8'h20);
        check({30'h0, rrs}, {30'h0, RESP_SLVERR});
        wr(8'h20, 32'h0000_0000);
        check({30'h0, brs}, {30'h0, RESP_SLVERR});
        wr(IDX_PEAK_RESULT, 32'hFFFF_FFFF);
        check({30'h0, brs}, {30'h0, RESP_OKAY});
        rc(IDX_PEAK_RESULT, 32'h0);
        wr(IDX_THRESH_RESULT, 32'hFFFF_FFFF);
        rc(IDX_THRESH_RESULT, 32'h0);
        wr(IDX_VAR_CONTROL, 32'h0000_7FF0);
        rc(IDX_VAR_CONTROL, 32'h0);
        // capture passes: max, min, max with unreachable threshold
        for (int m = 0; m < 6; m++) begin
            mode = (m % 3 == 1);
            b = 8'(1 + ($random(seed) & 15));
            e = b + 8'($random(seed) & 15);
            thr = (m % 3 == 2) ? 6'h3F : 6'($random(seed));
            for (int k = 0; k < 256; k++)
                vals[k] = (k < b || k > e) ? (mode ? 6'h00 : 6'h3F) : 6'($random(seed));
            wr(IDX_SAMPLE_WINDOW, {16'h0, b, e});
            rc(IDX_SAMPLE_WINDOW, {16'h0, b, e});
            wr(IDX_REFLECT_CTRL, {20'h0, 1'b1, 3'h0, mode, 1'b0, thr});
            check({31'h0, negpk}, {31'h0, mode});
            rdv = 32'h800;
            while (rdv[11]) rd(IDX_REFLECT_CTRL);
            check(rdv, {24'h0, mode, 1'b0, thr});
            ex = exp_capture(b, e, mode, thr);
            rc(IDX_PEAK_RESULT, {16'h0, ex[15:0]});
            rd(IDX_THRESH_RESULT);
            check(ex[24] ? rdv : rdv & 32'hFF00, {16'h0, ex[31:16]});
        end
        // variance: offset of three from midpoint adds nine per sample
        for (int t = 0; t < 4; t++) begin
            wr(IDX_VAR_CONTROL, 32'(t * 2 + 1));
            rd(IDX_VAR_DATA);
            rd(IDX_VAR_DATA);
            rdv = 32'h0;
            while (!rdv[15]) rd(IDX_VAR_CONTROL);
            wr(IDX_VAR_CONTROL, 32'(t * 2 + 9));
            rc(IDX_VAR_DATA, 32'(18 * (t + 1) * UNIT));
            rc(IDX_VAR_DATA, 32'h0);
            rd(IDX_VAR_CONTROL);
            check(rdv & 32'h7FFF, 32'(t * 2 + 1));
        end
        close_out();
    end
endmodule : tb_top
bind cdrr_regs cdrr_monitor u_mon (
    .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .CLK_EN_I(CLK_EN_I),
    .AWREADY_O(AWREADY_O), .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I),
    .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O),
    .LAUNCH_PULSE_O(LAUNCH_PULSE_O), .NEG_PEAK_SEL_O(NEG_PEAK_SEL_O));
